// ===== design/ioc_cycle_ctl.sv
// i/o cycle controller: local-bus cycles to slow peripheral strobes
//
// Summary of operation
// - write strobe follows chip select by two clocks
// - write data latched, processor held until the write strobe rises
// - write strobe held long enough for data setup
// - peripheral takes write data on strobe rise
// - write data latched past strobe rise for hold
// - read strobe low one clock plus wait states
// - chip select and address latched past strobe
// - hold off next cycle until read data floats
// - uart ports in region, low byte lane
// - uart select from a20, a19 and region select
// - one extra clock for read recovery
// - region select with late strobe starts cycle
// - read strobe only when recovery is inactive
// - ready driven only while serving this cycle
`timescale 1ns/1ps
`default_nettype none
module ioc_cycle_ctl (
    input wire logic clk,
    input wire logic reset,
    input wire logic addr_strobe_n,
    input wire logic late_addr_strobe_n,
    input wire logic [31:3] cpu_addr,
    input wire logic cpu_write,
    input wire logic [7:0] cpu_data_in,
    output logic [7:0] cpu_data_out,
    output logic cpu_data_oe,
    output logic ready_n_out,
    output logic ready_oe,
    output logic uart_chip_sel,
    output logic [2:0] periph_addr,
    output logic periph_read_n,
    output logic periph_write_n,
    input wire logic [7:0] periph_data_in,
    output logic [7:0] periph_data_out,
    output logic periph_data_oe
);

    // ****************************************************************
    // decode
    // ****************************************************************
    // region hit: the peripheral space select
    function automatic logic region_hit(input logic [31:3] a);
        return a[ioc_pkg::REGION_MSB:ioc_pkg::REGION_LSB] == ioc_pkg::REGION_CODE;
    endfunction

    // uart hit: region select qualified by a20/a19
    function automatic logic uart_hit(input logic [31:3] a);
        return region_hit(a) &&
            (a[ioc_pkg::UART_SEL_HI:ioc_pkg::UART_SEL_LO] == ioc_pkg::UART_SEL_CODE);
    endfunction

    ioc_pkg::ioc_state_t state_reg;
    logic [ioc_pkg::CNT_W-1:0] cnt_reg;
    logic pending_reg;
    logic wr_reg;
    logic [7:0] rd_sync1_reg;
    logic [7:0] rd_sync2_reg;
    logic periph_space_sel;
    logic start_now;
    logic go_strobe;
    logic end_strobe;

    ioc_rec_if rec ();

    ioc_recovery u_recovery (
        .clk(clk),
        .reset(reset),
        .rec(rec)
    );

    // a cycle is an announced address with the late strobe in the region
    assign periph_space_sel = region_hit(cpu_addr);
    assign start_now = pending_reg && !late_addr_strobe_n && periph_space_sel;
    // strobe may begin after the setup delay only while recovery is idle
    assign go_strobe = !rec.busy &&
        ((state_reg == ioc_pkg::ST_SETUP && cnt_reg == '0) ||
        state_reg == ioc_pkg::ST_RECOVER);
    assign end_strobe = (state_reg == ioc_pkg::ST_STROBE) && (cnt_reg == '0);

    // ****************************************************************
    // address announce tracking
    // ****************************************************************
    // remembers the address strobe until the late strobe confirms it
    always_ff @(posedge clk)
    begin
        if (reset)
            pending_reg <= 1'b0;
        else if (!addr_strobe_n)
            pending_reg <= 1'b1;
        else if (!late_addr_strobe_n)
            pending_reg <= 1'b0;
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    // one counter serves setup and strobe width; they never overlap
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= ioc_pkg::ST_IDLE;
            cnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                ioc_pkg::ST_IDLE:
                begin
                    if (start_now && state_reg == ioc_pkg::ST_IDLE)
                    begin
                        state_reg <= ioc_pkg::ST_SETUP;
                        cnt_reg <= ioc_pkg::CS_SETUP_LAST;
                    end
                end
                ioc_pkg::ST_SETUP:
                begin
                    if (cnt_reg != '0)
                        cnt_reg <= cnt_reg - 4'h1;
                    else if (go_strobe)
                    begin
                        state_reg <= ioc_pkg::ST_STROBE;
                        cnt_reg <= ioc_pkg::STROBE_LAST;
                    end
                    else
                        state_reg <= ioc_pkg::ST_RECOVER;
                end
                ioc_pkg::ST_RECOVER:
                begin
                    if (go_strobe)
                    begin
                        state_reg <= ioc_pkg::ST_STROBE;
                        cnt_reg <= ioc_pkg::STROBE_LAST;
                    end
                end
                ioc_pkg::ST_STROBE:
                begin
                    if (cnt_reg != '0)
                        cnt_reg <= cnt_reg - 4'h1;
                    else
                        state_reg <= ioc_pkg::ST_READY;
                end
                ioc_pkg::ST_READY:
                    state_reg <= ioc_pkg::ST_IDLE;
                default:
                    state_reg <= ioc_pkg::ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // latched select and address
    // ****************************************************************
    // latched so both outlast the strobe; select drops after ready
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            uart_chip_sel <= 1'b0;
            periph_addr <= '0;
            wr_reg <= 1'b0;
        end
        else if (state_reg == ioc_pkg::ST_IDLE && start_now)
        begin
            uart_chip_sel <= uart_hit(cpu_addr);
            periph_addr <= cpu_addr[ioc_pkg::PORT_LSB+ioc_pkg::PORT_W-1:ioc_pkg::PORT_LSB];
            wr_reg <= cpu_write;
        end
        else if (state_reg == ioc_pkg::ST_READY)
            uart_chip_sel <= 1'b0;
    end

    // ****************************************************************
    // command strobes
    // ****************************************************************
    // strobes rise together with ready so the select still holds
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            periph_read_n <= 1'b1;
            periph_write_n <= 1'b1;
        end
        else if (go_strobe)
        begin
            periph_read_n <= wr_reg;
            periph_write_n <= !wr_reg;
        end
        else if (end_strobe)
        begin
            periph_read_n <= 1'b1;
            periph_write_n <= 1'b1;
        end
    end

    // ****************************************************************
    // write data path
    // ****************************************************************
    // data taken in the second final address state, held to the end
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            periph_data_out <= '0;
            periph_data_oe <= 1'b0;
        end
        else if (state_reg == ioc_pkg::ST_SETUP && cnt_reg == ioc_pkg::CS_SETUP_LAST)
        begin
            if (wr_reg)
                periph_data_out <= cpu_data_in;
            periph_data_oe <= wr_reg;
        end
        else if (state_reg == ioc_pkg::ST_READY)
            periph_data_oe <= 1'b0;
    end

    // ****************************************************************
    // read data path
    // ****************************************************************
    // the uart answers without our clock, so its byte is synchronised
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rd_sync1_reg <= '0;
            rd_sync2_reg <= '0;
        end
        else
        begin
            rd_sync1_reg <= periph_data_in;
            rd_sync2_reg <= rd_sync1_reg;
        end
    end

    // read byte goes out on the lowest lane during the ready clock
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cpu_data_out <= '0;
            cpu_data_oe <= 1'b0;
        end
        else
        begin
            if (end_strobe && !wr_reg)
                cpu_data_out <= rd_sync2_reg;
            cpu_data_oe <= end_strobe && !wr_reg;
        end
    end

    // ****************************************************************
    // ready and recovery start
    // ****************************************************************
    // ready on the same edge the strobe rises: latching plus late ready is safe
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ready_n_out <= 1'b1;
            ready_oe <= 1'b0;
            rec.start <= 1'b0;
        end
        else
        begin
            ready_n_out <= !end_strobe;
            ready_oe <= end_strobe;
            rec.start <= end_strobe && !wr_reg;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    cycle_start_a: assert property (state_reg == ioc_pkg::ST_IDLE && start_now
        |=> state_reg == ioc_pkg::ST_SETUP)
        else $error("cycle did not start");
    write_setup_a: assert property ($fell(periph_write_n)
        |-> $past(state_reg, 2) != ioc_pkg::ST_IDLE)
        else $error("write strobe too soon after select");
    read_width_a: assert property ($fell(periph_read_n)
        |-> (!periph_read_n)[*8] ##1 !periph_read_n ##1 !periph_read_n ##1 periph_read_n)
        else $error("read strobe width not ten clocks");
    write_width_a: assert property ($fell(periph_write_n)
        |-> ##9 !periph_write_n ##1 periph_write_n)
        else $error("write strobe width not ten clocks");
    write_hold_a: assert property ($rose(periph_write_n)
        |-> periph_data_oe && $stable(periph_data_out))
        else $error("write data not held at strobe rise");
    select_hold_a: assert property ($rose(periph_read_n) || $rose(periph_write_n)
        |-> $stable(uart_chip_sel) && $stable(periph_addr))
        else $error("select changed at strobe rise");
    ready_once_a: assert property ($rose(periph_read_n) || $rose(periph_write_n)
        |-> !ready_n_out && ready_oe ##1 ready_n_out && !ready_oe && !uart_chip_sel)
        else $error("ready not a single pulse after strobe");
    ready_float_a: assert property (state_reg != ioc_pkg::ST_READY |-> !ready_oe)
        else $error("ready driven outside own cycle");
    read_gap_a: assert property ($rose(periph_read_n) |-> periph_read_n[*8])
        else $error("read recovery too short");
    no_recover_a: assert property ($fell(periph_read_n) |-> !$past(rec.busy))
        else $error("read strobe during recovery");

    read_cycle_c: cover property ($fell(periph_read_n) ##[1:20] !ready_n_out);
    write_cycle_c: cover property ($fell(periph_write_n) ##[1:20] !ready_n_out);
    read_wait_c: cover property (state_reg == ioc_pkg::ST_RECOVER ##[1:20] $fell(periph_read_n));

endmodule
`default_nettype wire

// ===== design/ioc_pkg.sv
// shared constants and types for the i/o cycle controller
package ioc_pkg;

    // ****************************************************************
    // clock and counter widths
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int CNT_W = 4;

    // ****************************************************************
    // cycle timing
    // ****************************************************************
    // chip select leads either strobe by this many clocks
    localparam int CS_SETUP_CLKS_INT = 2;
    localparam logic [CNT_W-1:0] CS_SETUP_LAST = 4'h1;
    // wait states added to the one-clock base strobe width
    localparam int WAIT_STATES = 9;
    localparam int STROBE_CLKS_INT = 1 + WAIT_STATES;
    localparam logic [CNT_W-1:0] STROBE_LAST = 4'h9;
    // peripheral read data float after the read strobe rises
    localparam int FLOAT_NS = 40;
    // peripheral read inactive-to-active recovery
    localparam int RECOVERY_NS = 123;
    localparam int RECOV_EXTRA_CLKS = 1;
    localparam int FLOAT_CLKS_INT = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOV_CLKS_INT = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLDOFF_CLKS_INT =
        ((RECOV_CLKS_INT > FLOAT_CLKS_INT) ? RECOV_CLKS_INT : FLOAT_CLKS_INT)
        + RECOV_EXTRA_CLKS;
    localparam logic [CNT_W-1:0] HOLDOFF_CLKS = HOLDOFF_CLKS_INT[CNT_W-1:0];

    // ****************************************************************
    // address decode
    // ****************************************************************
    localparam int ADDR_LSB = 3;
    localparam int REGION_MSB = 31;
    localparam int REGION_LSB = 24;
    localparam logic [7:0] REGION_CODE = 8'h07;
    localparam int UART_SEL_HI = 20;
    localparam int UART_SEL_LO = 19;
    localparam logic [1:0] UART_SEL_CODE = 2'h0;
    localparam int PORT_LSB = 3;
    localparam int PORT_W = 3;
    localparam int BYTE_W = 8;

    // ****************************************************************
    // controller states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_SETUP   = 3'h1,
        ST_RECOVER = 3'h2,
        ST_STROBE  = 3'h3,
        ST_READY   = 3'h4
    } ioc_state_t;

endpackage

// ===== design/ioc_rec_if.sv
// recovery handshake between the cycle sequencer and the hold-off timer
`timescale 1ns/1ps
`default_nettype none
interface ioc_rec_if;
    logic start;
    logic busy;
    modport ctrl (output start, input busy);
    modport timer (input start, output busy);
endinterface
`default_nettype wire

// ===== design/ioc_recovery.sv
// hold-off timer that blocks new strobes while read data floats
`timescale 1ns/1ps
`default_nettype none
module ioc_recovery (
    input wire logic clk,
    input wire logic reset,
    ioc_rec_if.timer rec
);

    // ****************************************************************
    // hold-off counter
    // ****************************************************************
    logic [ioc_pkg::CNT_W-1:0] cnt_reg;

    // busy comes from a flop so the sequencer sees a clean level
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cnt_reg <= '0;
            rec.busy <= 1'b0;
        end
        else if (rec.start)
        begin
            cnt_reg <= ioc_pkg::HOLDOFF_CLKS;
            rec.busy <= 1'b1;
        end
        else if (cnt_reg > 4'h1)
        begin
            cnt_reg <= cnt_reg - 4'h1;
        end
        else
        begin
            cnt_reg <= '0;
            rec.busy <= 1'b0;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    holdoff_length_a: assert property ($rose(rec.busy) |-> rec.busy[*8] ##1 !rec.busy)
        else $error("recovery hold-off is not eight clocks");

endmodule
`default_nettype wire

// ===== dv/ioc_periph_model.sv
// behavioural model of the slow byte-wide peripheral behind the strobes
`timescale 1ns/1ps
`default_nettype none
module ioc_periph_model #(
    parameter real MIN_STROBE_T = 199.0,
    parameter real SETUP_T = 39.0,
    parameter real FLOAT_T = 40.0,
    parameter real RECOV_T = 123.0,
    parameter real HOLD_T = 8.0,
    parameter real FAST_T = 30.0,
    parameter real SLOW_T = 140.0
) (
    input wire logic uart_chip_sel,
    input wire logic [2:0] periph_addr,
    input wire logic periph_read_n,
    input wire logic periph_write_n,
    input wire logic [7:0] periph_data_out,
    input wire logic periph_data_oe,
    input wire logic slow,
    output logic [7:0] periph_data_in,
    output int viol_count
);
    // ****************************************************************
    // port storage and timing bookkeeping
    // ****************************************************************
    logic [7:0] port_reg [8];
    logic [7:0] last_byte;
    logic [2:0] fall_addr;
    logic fall_cs;
    logic in_rd;
    logic in_wr;
    realtime rd_rise_t;
    realtime cs_rise_t;
    realtime fall_t;

    initial
    begin
        viol_count = 0;
        last_byte = 8'h00;
        periph_data_in = 8'hff;
        in_rd = 1'b0;
        in_wr = 1'b0;
        rd_rise_t = -1000.0;
        cs_rise_t = 0.0;
        fall_t = 0.0;
        for (int i = 0; i < 8; i++)
            port_reg[i] = 8'h00;
    end

    always @(posedge uart_chip_sel) cs_rise_t = $realtime;

    // read start: bus shows junk until the access time has passed
    always @(negedge periph_read_n)
    begin
        in_rd = 1'b1;
        fall_addr = periph_addr;
        fall_cs = uart_chip_sel;
        fall_t = $realtime;
        periph_data_in = ~last_byte;
        if (uart_chip_sel === 1'b1 && $realtime - cs_rise_t < SETUP_T) viol_count++;
        if ($realtime - rd_rise_t < RECOV_T) viol_count++;
        #(slow ? SLOW_T : FAST_T);
        if (periph_read_n === 1'b0 && fall_cs === 1'b1)
        begin
            last_byte = port_reg[fall_addr];
            periph_data_in = last_byte;
        end
    end

    // read end: data keeps driving for the float time, then goes stale
    always @(posedge periph_read_n)
    begin
        if (in_rd)
        begin
            in_rd = 1'b0;
            rd_rise_t = $realtime;
            if ($realtime - fall_t < MIN_STROBE_T) viol_count++;
            if (periph_addr !== fall_addr || uart_chip_sel !== fall_cs) viol_count++;
            #(FLOAT_T);
            periph_data_in = ~last_byte;
        end
    end

    always @(negedge periph_write_n)
    begin
        in_wr = 1'b1;
        fall_addr = periph_addr;
        fall_cs = uart_chip_sel;
        fall_t = $realtime;
        if (uart_chip_sel === 1'b1 && $realtime - cs_rise_t < SETUP_T) viol_count++;
    end

    // byte is taken on the trailing edge; data must outlast it
    always @(posedge periph_write_n)
    begin
        if (in_wr)
        begin
            in_wr = 1'b0;
            if ($realtime - fall_t < MIN_STROBE_T) viol_count++;
            if (periph_addr !== fall_addr || uart_chip_sel !== fall_cs) viol_count++;
            if (periph_data_oe !== 1'b1) viol_count++;
            if (fall_cs === 1'b1) port_reg[fall_addr] = periph_data_out;
            #(HOLD_T);
            if (periph_data_oe !== 1'b1) viol_count++;
        end
    end

    // driving write data while read data still floats is contention
    always @(posedge periph_data_oe)
        if ($realtime - rd_rise_t < FLOAT_T) viol_count++;
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the i/o cycle controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("wrong value %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module tb_top;
    // ****************************************************************
    // signals, clock and instances
    // ****************************************************************
    // setup clocks, strobe clocks, then the ready clock seen at its negedge
    localparam int BASE_LAT = ioc_pkg::CS_SETUP_CLKS_INT + ioc_pkg::STROBE_CLKS_INT + 1;
    logic clk;
    logic reset;
    logic addr_strobe_n;
    logic late_addr_strobe_n;
    logic [31:3] cpu_addr;
    logic cpu_write;
    logic [7:0] cpu_drv;
    logic cpu_drv_en;
    wire logic [7:0] cpu_bus;
    logic [7:0] cpu_data_out;
    logic cpu_data_oe;
    logic ready_n_out;
    logic ready_oe;
    wire logic ready_line;
    logic uart_chip_sel;
    logic [2:0] periph_addr;
    logic periph_read_n;
    logic periph_write_n;
    logic [7:0] periph_data_in;
    logic [7:0] periph_data_out;
    logic periph_data_oe;
    logic slow;
    int viol_count;
    int err_count;
    int compares;

    // released lines: ready has a pull-up, the data bus goes stale
    assign ready_line = ready_oe ? ready_n_out : 1'b1;
    assign cpu_bus = cpu_data_oe ? cpu_data_out : (cpu_drv_en ? cpu_drv : ~cpu_drv);

    initial clk = 1'b0;
    always #10 clk = ~clk;

    ioc_cycle_ctl i_dut (.clk(clk), .reset(reset), .addr_strobe_n(addr_strobe_n),
        .late_addr_strobe_n(late_addr_strobe_n), .cpu_addr(cpu_addr), .cpu_write(cpu_write),
        .cpu_data_in(cpu_bus), .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe),
        .ready_n_out(ready_n_out), .ready_oe(ready_oe), .uart_chip_sel(uart_chip_sel),
        .periph_addr(periph_addr), .periph_read_n(periph_read_n),
        .periph_write_n(periph_write_n), .periph_data_in(periph_data_in),
        .periph_data_out(periph_data_out), .periph_data_oe(periph_data_oe));

    ioc_periph_model #(
        .MIN_STROBE_T(ioc_pkg::STROBE_CLKS_INT * ioc_pkg::CLK_PERIOD_NS - 1),
        .SETUP_T(ioc_pkg::CS_SETUP_CLKS_INT * ioc_pkg::CLK_PERIOD_NS - 1)
    ) i_model (.uart_chip_sel(uart_chip_sel), .periph_addr(periph_addr),
        .periph_read_n(periph_read_n), .periph_write_n(periph_write_n),
        .periph_data_out(periph_data_out), .periph_data_oe(periph_data_oe), .slow(slow),
        .periph_data_in(periph_data_in), .viol_count(viol_count));

    function automatic logic [7:0] pat(input int p);
        return 8'hc3 ^ 8'(p * 8'h25);
    endfunction

    task automatic report_and_stop();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // processor address phase; write data goes out in the final address state
    task automatic addr_phase(input logic [31:0] addr, input logic wr, input logic [7:0] wdata);
        @(posedge clk);
        addr_strobe_n <= 1'b0;
        cpu_addr <= addr[31:3];
        cpu_write <= wr;
        @(posedge clk);
        addr_strobe_n <= 1'b1;
        late_addr_strobe_n <= 1'b0;
        cpu_drv_en <= wr;
        cpu_drv <= wdata;
        @(posedge clk);
        late_addr_strobe_n <= 1'b1;
    endtask

    // one full cycle; latency counts negedges from the late strobe release
    task automatic io_cycle(input logic [31:0] addr, input logic wr, input logic [7:0] wdata,
        output logic [7:0] rdata, output int lat);
        addr_phase(addr, wr, wdata);
        lat = 0;
        while (ready_line !== 1'b0 && lat < 60)
        begin
            @(negedge clk);
            lat++;
        end
        if (ready_line !== 1'b0)
        begin
            err_count++;
            report_and_stop();
        end
        rdata = cpu_bus;
        if (!wr)
            `CHK("read drive", 1'b1, cpu_data_oe)
        @(posedge clk);
        cpu_drv_en <= 1'b0;
        @(negedge clk);
        `CHK("ready released", 1'b0, ready_oe)
        `CHK("select unlatched", 1'b0, uart_chip_sel)
    endtask

    task automatic t_reset_values();
        repeat (3) @(posedge clk);
        @(negedge clk);
        `CHK("reset read strobe", 1'b1, periph_read_n)
        `CHK("reset write strobe", 1'b1, periph_write_n)
        `CHK("reset ready drive", 1'b0, ready_oe)
        `CHK("reset select", 1'b0, uart_chip_sel)
        @(posedge clk);
        reset <= 1'b0;
    endtask

    // back-to-back writes to all eight ports need no hold-off
    task automatic t_write_ports();
        logic [7:0] rd;
        int lat;
        for (int p = 0; p < 8; p++)
        begin
            io_cycle(32'h0700_0000 | 32'(p << 3), 1'b1, pat(p), rd, lat);
            `CHK("write latency", BASE_LAT, lat)
        end
        for (int p = 0; p < 8; p++)
            `CHK("port content", pat(p), i_model.port_reg[p])
    endtask

    // reads after a read must be held off for float and recovery
    task automatic t_read_ports();
        logic [7:0] rd;
        int lat;
        for (int p = 0; p < 8; p++)
        begin
            io_cycle(32'h0700_0000 | 32'(p << 3), 1'b0, 8'h00, rd, lat);
            `CHK("read byte", pat(p), rd)
            `CHK("read hold-off", p > 0, lat > BASE_LAT)
        end
    endtask

    task automatic t_slow_read_then_write();
        logic [7:0] rd;
        int lat;
        slow = 1'b1;
        io_cycle(32'h0700_0028, 1'b0, 8'h00, rd, lat);
        `CHK("slow read byte", pat(5), rd)
        io_cycle(32'h0700_0028, 1'b1, 8'h96, rd, lat);
        `CHK("write after read hold-off", 1'b1, lat > BASE_LAT)
        `CHK("port after write", 8'h96, i_model.port_reg[5])
        slow = 1'b0;
    endtask

    // select decode and cycles outside the region
    task automatic t_decode();
        logic [7:0] rd;
        int lat;
        int seen;
        io_cycle(32'h0708_0018, 1'b1, 8'h3c, rd, lat);
        `CHK("unselected write", pat(3), i_model.port_reg[3])
        io_cycle(32'h07e0_0018, 1'b1, 8'h3c, rd, lat);
        `CHK("upper region write", 8'h3c, i_model.port_reg[3])
        seen = 0;
        addr_phase(32'h0800_0018, 1'b1, 8'h5a);
        repeat (30)
        begin
            @(negedge clk);
            if (ready_line !== 1'b1 || periph_write_n !== 1'b1)
                seen++;
        end
        `CHK("ignored cycle activity", 32'h0, seen)
        @(posedge clk);
        cpu_drv_en <= 1'b0;
    endtask

    initial
    begin
        reset = 1'b1;
        addr_strobe_n = 1'b1;
        late_addr_strobe_n = 1'b1;
        cpu_addr = '0;
        cpu_write = 1'b0;
        cpu_drv = 8'h00;
        cpu_drv_en = 1'b0;
        slow = 1'b0;
        err_count = 0;
        compares = 0;
        t_reset_values();
        t_write_ports();
        t_read_ports();
        t_slow_read_then_write();
        t_decode();
        `CHK("peripheral timing faults", 32'h0, viol_count)
        report_and_stop();
    end
endmodule
`default_nettype wire
